//--- logic/payload_pkg.sv
// Shared constants and types for the coverage and barycentric payload builder
package payload_pkg;
  // Register offsets on the plain register port
  localparam logic [3:0] ADDR_CFG    = 4'h0;
  localparam logic [3:0] ADDR_BASE   = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  // Field positions
  localparam int CFG_WIDTH      = 5;
  localparam int STS_BUSY_BIT   = 0;
  localparam int STS_COUNT_LSB  = 4;
  localparam int STS_STATE_LSB  = 8;
  // Reset values
  localparam logic [4:0] CFG_RESET  = 5'h00;
  localparam logic [7:0] BASE_RESET = 8'h20;
  // Dispatch width codes
  localparam logic [1:0] DISP_8  = 2'h0;
  localparam logic [1:0] DISP_16 = 2'h1;
  localparam logic [1:0] DISP_32 = 2'h2;
  // Payload geometry
  localparam int WORD_BITS  = 32;
  localparam int REG_WORDS  = 8;
  localparam int COV_SLOTS  = 16;

  typedef logic [WORD_BITS-1:0]                 word_t;
  typedef logic [REG_WORDS-1:0][WORD_BITS-1:0]  preg_t;
  typedef logic [COV_SLOTS-1:0][WORD_BITS-1:0]  cov_arr_t;

  // Bit 0 use coverage, 1 coarse rate, 3:2 width, 4 bary enable
  typedef struct packed {
    logic       bary_en;
    logic [1:0] width;
    logic       coarse;
    logic       use_cov;
  } cfg_t;

  // Gray codes along idle, cov lo, cov hi, bary1, bary2, finish
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_COV_LO = 3'h1,
    ST_COV_HI = 3'h3,
    ST_BARY1  = 3'h2,
    ST_BARY2  = 3'h6,
    ST_FINISH = 3'h7
  } pstate_t;
endpackage

//--- logic/coverage_word_select.sv
// Per-slot choice between sample and pixel coverage masks
`timescale 1ns/1ns
module coverage_word_select
  import payload_pkg::*;
#(
  parameter int SLOTS = COV_SLOTS
) (
  // Clock and reset for the checks
  input  wire logic                        i_clock,
  input  wire logic                        i_sys_rst,
  // Mask sources
  input  wire logic                        i_coarse,
  input  wire logic [SLOTS-1:0][WORD_BITS-1:0] i_sample_mask,
  input  wire logic [SLOTS-1:0][WORD_BITS-1:0] i_pixel_mask,
  // Selected words
  output logic      [SLOTS-1:0][WORD_BITS-1:0] o_word
);
  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_slot
      assign o_word[g] = i_coarse ? i_pixel_mask[g] : i_sample_mask[g];
    end
  endgenerate

  chk_rate_select: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (!i_coarse || o_word[0] == i_pixel_mask[0]) &&
    (i_coarse || o_word[SLOTS-1] == i_sample_mask[SLOTS-1]))
    else $error("coverage word not taken from the mask of the dispatch rate");
endmodule

//--- logic/pixel_payload_coverage_bary.sv
// Builder of coverage and first perspective barycentric payload registers
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
// Notes on behaviour
// - First coverage register needs coverage flag
// - Coverage slots 0-7, dword equals slot
// - Sample masks pixel rate, pixel masks coarse
// - Second coverage register needs flag, not 8-wide
// - Slots 8-15 in dwords 0-7
// - Barycentrics only 32-wide and mode enabled
// - Barycentric one, slots 16-23, dword order
// - Barycentric two follows, same ordering
// - One enable gates both barycentric registers
module pixel_payload_coverage_bary
  import payload_pkg::*;
(
  // Clock and reset
  input  wire logic                     i_clock,
  input  wire logic                     i_sys_rst,
  // Register port
  input  wire logic [3:0]               i_reg_addr,
  input  wire logic [31:0]              i_reg_wdata,
  input  wire logic                     i_reg_write,
  input  wire logic                     i_reg_read,
  output logic      [31:0]              o_reg_rdata,
  // Dispatch request and slot data
  input  wire logic                     i_start,
  input  wire cov_arr_t                 i_sample_mask,
  input  wire cov_arr_t                 i_pixel_mask,
  input  wire preg_t                    i_bary1,
  input  wire preg_t                    i_bary2,
  // Payload register stream to the thread
  output logic                          o_preg_valid,
  input  wire logic                     i_preg_ready,
  output preg_t                         o_preg_data,
  output logic      [7:0]               o_preg_index,
  output logic                          o_busy,
  output logic                          o_done
);
  cfg_t       cfg_q;
  cfg_t       run_cfg_q;
  logic [7:0] base_q;
  logic [31:0] rdata_q;
  pstate_t    state_q;
  pstate_t    state_d;
  preg_t      data_q;
  logic [7:0] index_q;
  logic [2:0] count_q;
  cov_arr_t   cov_sel;
  cov_arr_t   cov_q;
  preg_t      b1_q;
  preg_t      b2_q;
  logic       accept;
  logic       launch;

  assign launch = i_start && state_q == ST_IDLE;
  assign accept = o_preg_valid && i_preg_ready;

  coverage_word_select #(.SLOTS(COV_SLOTS)) u_cov_sel (
    .i_clock       (i_clock),
    .i_sys_rst     (i_sys_rst),
    .i_coarse      (cfg_q.coarse),
    .i_sample_mask (i_sample_mask),
    .i_pixel_mask  (i_pixel_mask),
    .o_word        (cov_sel)
  );

  // Next included register after a given one, in payload order
  function automatic pstate_t next_incl(input pstate_t from, input cfg_t c);
    logic cov_lo;
    logic cov_hi;
    logic bary;
    pstate_t n;
    cov_lo = c.use_cov;
    cov_hi = c.use_cov && c.width != DISP_8;
    bary   = c.bary_en && c.width == DISP_32;
    n = ST_FINISH;
    case (from)
      ST_IDLE:   n = cov_lo ? ST_COV_LO : (cov_hi ? ST_COV_HI : (bary ? ST_BARY1 : ST_FINISH));
      ST_COV_LO: n = cov_hi ? ST_COV_HI : (bary ? ST_BARY1 : ST_FINISH);
      ST_COV_HI: n = bary ? ST_BARY1 : ST_FINISH;
      ST_BARY1:  n = ST_BARY2;
      default:   n = ST_FINISH;
    endcase
    return n;
  endfunction

  // Register writes; configuration is sampled per dispatch at launch
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      cfg_q  <= cfg_t'(CFG_RESET);
      base_q <= BASE_RESET;
    end else if (i_reg_write) begin
      if (i_reg_addr == ADDR_CFG) begin
        cfg_q <= cfg_t'(i_reg_wdata[CFG_WIDTH-1:0]);
      end
      if (i_reg_addr == ADDR_BASE) begin
        base_q <= i_reg_wdata[7:0];
      end
    end
  end

  // Read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_reg_read) begin
      case (i_reg_addr)
        ADDR_CFG:    rdata_q <= {27'h0, cfg_q};
        ADDR_BASE:   rdata_q <= {24'h00_0000, base_q};
        ADDR_STATUS: begin
          rdata_q <= 32'h0000_0000;
          rdata_q[STS_BUSY_BIT] <= o_busy;
          rdata_q[STS_COUNT_LSB +: 3] <= count_q;
          rdata_q[STS_STATE_LSB +: 3] <= state_q;
        end
        default:     rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end
  assign o_reg_rdata = rdata_q;

  // Slot data held for the whole dispatch so the source may move on
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      run_cfg_q <= cfg_t'(CFG_RESET);
      cov_q     <= '0;
      b1_q      <= '0;
      b2_q      <= '0;
    end else if (launch) begin
      run_cfg_q <= cfg_q;
      cov_q     <= cov_sel;
      b1_q      <= i_bary1;
      b2_q      <= i_bary2;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:   if (i_start) state_d = next_incl(ST_IDLE, cfg_q);
      ST_COV_LO,
      ST_COV_HI,
      ST_BARY1,
      ST_BARY2:  if (i_preg_ready) state_d = next_incl(state_q, run_cfg_q);
      ST_FINISH: state_d = ST_IDLE;
      default:   state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Payload word loaded on entry; launch cycle reads live sources
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      data_q <= '0;
    end else if (state_d != state_q) begin
      case (state_d)
        ST_COV_LO: data_q <= launch ? preg_t'(cov_sel[7:0]) : preg_t'(cov_q[7:0]);
        ST_COV_HI: data_q <= launch ? preg_t'(cov_sel[15:8]) : preg_t'(cov_q[15:8]);
        ST_BARY1:  data_q <= launch ? i_bary1 : b1_q;
        ST_BARY2:  data_q <= b2_q;
        default:   data_q <= '0;
      endcase
    end
  end

  // Position counter never skips, so omitted registers leave no gap
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      index_q <= BASE_RESET;
      count_q <= 3'h0;
    end else if (launch) begin
      index_q <= base_q;
      count_q <= 3'h0;
    end else if (accept) begin
      index_q <= index_q + 8'h01;
      count_q <= count_q + 3'h1;
    end
  end

  assign o_preg_valid = state_q == ST_COV_LO || state_q == ST_COV_HI ||
                        state_q == ST_BARY1 || state_q == ST_BARY2;
  assign o_preg_data  = data_q;
  assign o_preg_index = index_q;
  assign o_busy       = state_q != ST_IDLE;
  assign o_done       = state_q == ST_FINISH;

  chk_cov_lo_gate: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    state_q == ST_COV_LO |-> run_cfg_q.use_cov)
    else $error("first coverage register sent without the coverage flag");

  chk_cov_lo_slot: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    state_q == ST_COV_LO |-> o_preg_data[6] == cov_q[6] && o_preg_data[0] == cov_q[0])
    else $error("first coverage register dword does not match its slot");

  chk_cov_hi_gate: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    state_q == ST_COV_HI |-> run_cfg_q.use_cov && run_cfg_q.width != DISP_8)
    else $error("second coverage register sent for an 8-pixel dispatch");

  chk_cov_hi_slot: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    state_q == ST_COV_HI |-> o_preg_data[7] == cov_q[15] && o_preg_data[0] == cov_q[8])
    else $error("second coverage register dword does not match its slot");

  chk_bary_gate: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (state_q == ST_BARY1 || state_q == ST_BARY2) |->
      run_cfg_q.bary_en && run_cfg_q.width == DISP_32)
    else $error("barycentric register sent without 32-pixel mode and enable");

  chk_bary1_slot: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    state_q == ST_BARY1 |-> o_preg_data[7] == b1_q[7] && o_preg_data[0] == b1_q[0])
    else $error("barycentric one dword does not match its slot");

  chk_bary2_data: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    state_q == ST_BARY1 && i_preg_ready |=>
      o_preg_data[7] == b2_q[7] && o_preg_data[0] == b2_q[0])
    else $error("barycentric two does not follow with its slot data");

  chk_bary_pair: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (state_q == ST_BARY1 && i_preg_ready |=> state_q == ST_BARY2) and
    (state_q == ST_BARY2 |-> $past(state_q) inside {ST_BARY1, ST_BARY2}))
    else $error("barycentric registers not sent as a pair");

  chk_index_step: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (accept ##1 o_preg_valid) |-> o_preg_index == $past(o_preg_index) + 8'h01)
    else $error("payload position skipped or repeated");

  chk_index_base: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    launch |=> o_preg_index == $past(base_q))
    else $error("first payload position is not the base");
endmodule

//--- verif/thread_sink.sv
// Thread side model that takes payload registers, promptly or slowly
`timescale 1ns/1ns
module thread_sink
  import payload_pkg::*;
(
  // Clock, reset and bench control
  input  wire logic       i_clock,
  input  wire logic       i_sys_rst,
  input  wire logic       i_slow,
  input  wire logic       i_clear,
  // Payload stream
  input  wire logic       i_valid,
  input  wire preg_t      i_data,
  input  wire logic [7:0] i_index,
  output logic            o_ready
);
  preg_t      got_data  [8];
  logic [7:0] got_index [8];
  int         got_count;
  logic [1:0] div_q;

  // Slow mode takes one register in four cycles
  always_ff @(posedge i_clock) begin
    div_q <= i_sys_rst ? 2'h0 : div_q + 2'h1;
    o_ready <= !i_sys_rst && (!i_slow || div_q == 2'h2);
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst || i_clear) begin
      got_count <= 0;
    end else if (i_valid && o_ready && got_count < 8) begin
      got_data[got_count]  <= i_data;
      got_index[got_count] <= i_index;
      got_count            <= got_count + 1;
    end
  end
endmodule

//--- verif/pixel_payload_coverage_bary_tb.sv
// Self-checking bench for the coverage and barycentric payload builder
`timescale 1ns/1ns
module pixel_payload_coverage_bary_tb;
  import payload_pkg::*;
  logic        i_clock, i_sys_rst, i_reg_write, i_reg_read, i_start, rdy, slow, clr;
  logic [3:0]  i_reg_addr;
  logic [31:0] i_reg_wdata, o_reg_rdata;
  cov_arr_t    smp, pix;
  preg_t       b1, b2, o_preg_data;
  logic        o_preg_valid, o_busy, o_done;
  logic [7:0]  o_preg_index;
  int          mismatches, cmp_count;

  pixel_payload_coverage_bary u_pixel_payload_coverage_bary (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_write(i_reg_write), .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata),
    .i_start(i_start), .i_sample_mask(smp), .i_pixel_mask(pix), .i_bary1(b1), .i_bary2(b2),
    .o_preg_valid(o_preg_valid), .i_preg_ready(rdy), .o_preg_data(o_preg_data),
    .o_preg_index(o_preg_index), .o_busy(o_busy), .o_done(o_done));
  thread_sink u_thread_sink (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_slow(slow),
    .i_clear(clr), .i_valid(o_preg_valid), .i_data(o_preg_data), .i_index(o_preg_index),
    .o_ready(rdy));

  initial begin
    i_clock = 0;
    forever #4 i_clock = ~i_clock;
  end

  task automatic check(input string name, input logic [255:0] seen, input logic [255:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_reg_write <= 1'b1;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    @(posedge i_clock);
    i_reg_write <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
    @(posedge i_clock);
    i_reg_read <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clock);
    i_reg_read <= 1'b0;
    @(posedge i_clock);
    check("reg_rdata", o_reg_rdata, exp);
  endtask

  // Builds the expected register list, then runs one dispatch
  task automatic run_case(input logic [4:0] cfg, input logic slow_in);
    preg_t      exp_q[$];
    preg_t      r1, r2;
    logic [7:0] base;
    int         cyc;
    base = {3'h2, cfg};
    for (int k = 0; k < 8; k++) begin
      r1[k] = cfg[1] ? pix[k] : smp[k];
      r2[k] = cfg[1] ? pix[k + 8] : smp[k + 8];
    end
    if (cfg[0]) exp_q.push_back(r1);
    if (cfg[0] && cfg[3:2] != DISP_8) exp_q.push_back(r2);
    if (cfg[4] && cfg[3:2] == DISP_32) begin
      exp_q.push_back(b1);
      exp_q.push_back(b2);
    end
    reg_write(ADDR_CFG, {27'h0, cfg});
    reg_write(ADDR_BASE, {24'h0, base});
    @(posedge i_clock);
    slow    <= slow_in;
    clr     <= 1'b1;
    i_start <= 1'b1;
    @(posedge i_clock);
    clr     <= 1'b0;
    i_start <= 1'b0;
    cyc = 0;
    if (slow_in) begin
      // Start and config change mid-dispatch must not disturb it
      @(posedge i_clock);
      i_start     <= 1'b1;
      i_reg_write <= 1'b1;
      i_reg_addr  <= ADDR_CFG;
      i_reg_wdata <= 32'h0;
      @(posedge i_clock);
      i_start     <= 1'b0;
      i_reg_write <= 1'b0;
      cyc = 2;
    end
    while (o_done !== 1'b1 && cyc < 60) begin
      @(posedge i_clock);
      cyc++;
    end
    if (!slow_in) check("done_cycle", cyc, exp_q.size() + 1);
    // A loop that ran out of cycles shows up here as a missing done
    check("done_pulse", o_done, 1'b1);
    check("done_valid", o_preg_valid, 1'b0);
    check("done_busy", o_busy, 1'b1);
    check("reg_count", u_thread_sink.got_count, exp_q.size());
    for (int k = 0; k < exp_q.size(); k++) begin
      check("preg_data", u_thread_sink.got_data[k], exp_q[k]);
      check("preg_index", u_thread_sink.got_index[k], base + k);
    end
    reg_read(ADDR_STATUS, exp_q.size() << STS_COUNT_LSB);
  endtask

  localparam logic [4:0] CASES [10] = '{5'h01, 5'h05, 5'h07, 5'h0d, 5'h19, 5'h18, 5'h14,
                                        5'h00, 5'h1b, 5'h19};

  initial begin
    repeat (20000) @(posedge i_clock);
    mismatches++;
    stop_test();
  end

  initial begin
    {i_sys_rst, i_reg_write, i_reg_read, i_start, slow, clr} = 6'h21;
    i_reg_addr  = 4'h0;
    i_reg_wdata = 32'h0;
    for (int n = 0; n < 16; n++) begin
      smp[n] = {24'ha5a5a5, n[7:0]};
      pix[n] = {24'hc3c3c3, n[7:0]};
    end
    for (int n = 0; n < 8; n++) begin
      b1[n] = 32'h3f800000 + n;
      b2[n] = 32'h40000000 + n;
    end
    repeat (16) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    @(posedge i_clock);
    check("reset_index", o_preg_index, 8'h20);
    check("reset_busy", o_busy, 1'b0);
    reg_read(ADDR_CFG, {27'h0, CFG_RESET});
    reg_read(ADDR_BASE, {24'h0, BASE_RESET});
    reg_write(4'hc, 32'h1f);
    reg_write(ADDR_STATUS, 32'h7ff);
    reg_read(4'hc, 32'h0);
    reg_read(ADDR_CFG, 32'h0);
    reg_read(ADDR_STATUS, 32'h0);
    for (int c = 0; c < 10; c++) run_case(CASES[c], c >= 8);
    stop_test();
  end
endmodule
